// ===== tcs_pkg.sv
// Shared constants for the trip circuit supervisor: register map, field
// positions, reset values and timebase figures.
// Assumes a 50 MHz system clock and a 32-bit APB register port.
`default_nettype none
package tcs_pkg;
	// ****************************************
	// Timebase
	// ****************************************
	localparam int unsigned CLK_HZ = 50_000_000; // System clock rate
	localparam int unsigned SAMPLE_MS = 500; // Sense input sampling interval
	localparam int unsigned SAMPLE_CYCLES_DEF = CLK_HZ / 1000 * SAMPLE_MS;
	localparam int unsigned SAMPLES_PER_SEC = 1000 / SAMPLE_MS; // Ticks per second
	localparam logic [5:0] TWO_INPUT_SAMPLES = 6'h03; // Consecutive samples, two-input mode
	localparam logic [4:0] DELAY_MIN_S = 5'h01; // One-input delay floor, seconds
	localparam logic [4:0] DELAY_MAX_S = 5'h1E; // One-input delay ceiling, seconds
	localparam int NUM_CIRC = 3; // Supervised circuits

	// ****************************************
	// Register map
	// ****************************************
	localparam int APB_AW = 8; // Address width
	localparam logic [7:0] CTRL_OFS = 8'h00; // Control, read/write
	localparam logic [7:0] ROUTE_OFS = 8'h04; // Input routing, read/write
	localparam logic [7:0] STATUS_OFS = 8'h08; // Status, read only
	localparam logic [7:0] INPUTS_OFS = 8'h0C; // Raw sense inputs, read only

	// CTRL fields
	localparam int CTRL_EN_BIT = 0; // Supervision switch
	localparam int CTRL_TWO_BIT = 1; // Inputs per circuit: 1 = two
	localparam int CTRL_CNT_LSB = 2; // Supervised circuit count, 2 bits
	localparam int CTRL_DLY_LSB = 8; // One-input delay in seconds, 5 bits
	localparam logic [31:0] CTRL_RESET = 32'h0000_020E; // Off, two inputs, 3 circuits, 2 s
	localparam logic [31:0] CTRL_MASK = 32'h0000_1F0F; // Implemented bits

	// ROUTE fields
	localparam int ROUTE_TRIP_LSB = 0; // Trip relay input routed, per circuit
	localparam int ROUTE_BRK_LSB = 4; // Breaker relay input routed, per circuit
	localparam logic [31:0] ROUTE_RESET = 32'h0000_0000;
	localparam logic [31:0] ROUTE_MASK = 32'h0000_0077;

	// STATUS fields
	localparam int STAT_FAIL_LSB = 0; // Per-circuit failure
	localparam int STAT_MISM_LSB = 4; // Per-circuit routing mismatch
	localparam int STAT_OFF_BIT = 8; // Supervision off
	localparam int STAT_CFAIL_BIT = 9; // Common failure output
	localparam int STAT_MANY_BIT = 10; // Any routing mismatch
endpackage
`default_nettype wire

// ===== tcs_chan_if.sv
// Carrier between the supervisor top and one circuit checker.
// Assumes one clock domain; sense inputs and freeze pass straight from top ports, unregistered.
`timescale 1ns/10ps
`default_nettype none
interface tcs_chan_if;
	logic sample_tick; // One-cycle sampling strobe
	logic active; // Circuit supervised and correctly routed
	logic freeze; // System fault in progress
	logic mode_two; // Two sense inputs in use
	logic first_in; // Trip relay sense input
	logic second_in; // Breaker relay sense input
	logic [5:0] limit; // One-input delay in sample ticks
	logic fail; // Debounced failure state
	modport ctrl (output sample_tick, active, freeze, mode_two, first_in, second_in, limit,
		input fail);
	modport chan (input sample_tick, active, freeze, mode_two, first_in, second_in, limit,
		output fail);
endinterface
`default_nettype wire

// ===== tcs_circuit.sv
// Debounce and failure state of one supervised trip circuit.
// Assumes sample_tick is a one-cycle pulse and limit is at least two.
`timescale 1ns/10ps
`default_nettype none
module tcs_circuit import tcs_pkg::*; (
	// Clock and reset
	input wire logic clk_i,
	input wire logic reset_i,
	// Channel
	tcs_chan_if.chan ch
);
	// ****************************************
	// Debounce counter
	// ****************************************
	logic [5:0] cnt_reg; // Consecutive samples disagreeing with fail
	logic [5:0] cnt_next;
	logic fail_reg; // Failure state
	logic fail_next;
	logic abnormal; // Current sample is abnormal
	logic [5:0] lim; // Samples needed to change state

	// Same count sets and clears the alarm, so both delays match
	always_comb begin
		abnormal = ch.mode_two ? (!ch.first_in && !ch.second_in) : !ch.first_in;
		lim = ch.mode_two ? TWO_INPUT_SAMPLES : ch.limit;
		cnt_next = cnt_reg;
		fail_next = fail_reg;
		if (!ch.active) begin
			// Disabled or misrouted circuit reports nothing
			cnt_next = '0;
			fail_next = 1'b0;
		end else if (ch.freeze) begin
			// Trip contacts legally close during faults; restart the count
			cnt_next = '0;
		end else if (ch.sample_tick) begin
			if (abnormal != fail_reg) begin
				if (cnt_reg == lim - 6'h01) begin
					fail_next = abnormal;
					cnt_next = '0;
				end else begin
					cnt_next = cnt_reg + 6'h01;
				end
			end else begin
				// Short excursions are forgotten
				cnt_next = '0;
			end
		end
	end

	// Register only
	always_ff @(posedge clk_i or posedge reset_i) begin
		if (reset_i) begin
			cnt_reg <= '0;
			fail_reg <= 1'b0;
		end else begin
			cnt_reg <= cnt_next;
			fail_reg <= fail_next;
		end
	end

	assign ch.fail = fail_reg;

	// ****************************************
	// Checks
	// ****************************************
	sequence s_last_sample;
		$past(ch.sample_tick) && $past(ch.active) && !$past(ch.freeze);
	endsequence

	AST_CHANGE_ON_TICK: assert property (@(posedge clk_i) disable iff (reset_i)
		$rose(fail_reg) |-> s_last_sample)
		else $error("Failure set outside a sampling tick");
	AST_TWO_SET: assert property (@(posedge clk_i) disable iff (reset_i)
		$rose(fail_reg) && $past(ch.mode_two) |-> $past(cnt_reg) == 6'h02)
		else $error("Two-input alarm not after three samples");
	AST_TWO_CLEAR: assert property (@(posedge clk_i) disable iff (reset_i)
		$fell(fail_reg) && $past(ch.active) && $past(ch.mode_two) |-> $past(cnt_reg) == 6'h02)
		else $error("Two-input alarm cleared after wrong delay");
	AST_ONE_SET: assert property (@(posedge clk_i) disable iff (reset_i)
		$rose(fail_reg) && !$past(ch.mode_two) |-> $past(cnt_reg) == $past(ch.limit) - 6'h01)
		else $error("One-input alarm not after wait time");
	AST_FREEZE: assert property (@(posedge clk_i) disable iff (reset_i)
		ch.freeze && ch.active |=> $stable(fail_reg) && cnt_reg == 6'h00)
		else $error("Supervision ran during a system fault");
	AST_NORMAL_FIRST_HIGH: assert property (@(posedge clk_i) disable iff (reset_i)
		ch.active && ch.first_in && !fail_reg |=> !fail_reg)
		else $error("Alarm raised while first input high");
	AST_INACTIVE: assert property (@(posedge clk_i) disable iff (reset_i)
		!ch.active |=> !fail_reg && cnt_reg == 6'h00)
		else $error("Inactive circuit kept state");
endmodule // tcs_circuit
`default_nettype wire

// ===== tcs_top.sv
// Trip circuit supervisor top: APB registers, sampling timebase, routing
// check and the common outputs; instantiates one checker per circuit.
// Assumes sense inputs and system_fault_i are synchronous to clk_i.
//
// The implementer's own choices: register access over APB and the address map.
`timescale 1ns/10ps
`default_nettype none
// Notes on behaviour
// - Each circuit uses one or two inputs.
// - Missing routing raises per-circuit mismatch alarm.
// - Two-input patterns other than both-low are normal.
// - Two-input: both low is sole fault.
// - Inputs sampled every 500 ms.
// - Two-input alarm after three abnormal samples.
// - Two-input alarm clears after same samples.
// - Two-input delay fixed, about 1-2 s.
// - One-input: high normal, low while tripping.
// - One-input: lasting low means circuit failure.
// - Brief one-input low raises no alarm.
// - One-input delay configurable, same clear delay.
// - No supervision during system fault handling.
// - Global switch and inputs-per-circuit setting.
// - Up to three circuits, two inputs each.
// - One-input delay 1 to 30 s, default 2.
// - Common failure output and off indication.
module tcs_top import tcs_pkg::*; #(
	parameter int unsigned SAMPLE_CYCLES = SAMPLE_CYCLES_DEF // Clocks per sample tick
) (
	// Clock and reset
	input wire logic clk_i,
	input wire logic reset_i,
	// APB slave
	input wire logic psel_i,
	input wire logic penable_i,
	input wire logic pwrite_i,
	input wire logic [APB_AW-1:0] paddr_i,
	input wire logic [31:0] pwdata_i,
	output logic [31:0] prdata_o,
	output logic pready_o,
	output logic pslverr_o,
	// Sense inputs and fault state
	input wire logic [NUM_CIRC-1:0] first_sense_input_i,
	input wire logic [NUM_CIRC-1:0] second_sense_input_i,
	input wire logic system_fault_i,
	// Alarms
	output logic trip_circuit_fail_o,
	output logic supervision_off_flag_o,
	output logic routing_mismatch_alarm_o,
	output logic [NUM_CIRC-1:0] circuit_mismatch_o
);
	// ****************************************
	// Helpers
	// ****************************************
	// Known register offset
	function automatic logic addr_ok(input logic [APB_AW-1:0] a);
		addr_ok = (a == CTRL_OFS) || (a == ROUTE_OFS) || (a == STATUS_OFS) || (a == INPUTS_OFS);
	endfunction

	// Keep the one-input delay inside its range
	function automatic logic [4:0] clamp_delay(input logic [4:0] d);
		if (d < DELAY_MIN_S) begin
			clamp_delay = DELAY_MIN_S;
		end else if (d > DELAY_MAX_S) begin
			clamp_delay = DELAY_MAX_S;
		end else begin
			clamp_delay = d;
		end
	endfunction

	// ****************************************
	// Register file
	// ****************************************
	logic [31:0] ctrl_reg; // Control
	logic [31:0] ctrl_next;
	logic [31:0] route_reg; // Routing
	logic [31:0] route_next;
	logic [31:0] prdata_reg; // Read data, loaded in setup
	logic [31:0] prdata_next;
	logic pready_reg; // High for the one access cycle
	logic pready_next;
	logic pslverr_reg; // Unmapped address
	logic pslverr_next;
	logic [NUM_CIRC-1:0] fail_vec; // Per-circuit failure
	logic fail_reg; // Common failure
	logic off_reg; // Supervision off
	logic many_reg; // Any mismatch
	logic [NUM_CIRC-1:0] mism_reg; // Per-circuit mismatch
	logic [31:0] status_word; // Status as read
	logic [31:0] inputs_word; // Raw inputs as read
	logic [4:0] wdelay; // Delay field of write data

	always_comb begin
		status_word = '0;
		status_word[STAT_FAIL_LSB +: NUM_CIRC] = fail_vec;
		status_word[STAT_MISM_LSB +: NUM_CIRC] = mism_reg;
		status_word[STAT_OFF_BIT] = off_reg;
		status_word[STAT_CFAIL_BIT] = fail_reg;
		status_word[STAT_MANY_BIT] = many_reg;
		inputs_word = '0;
		inputs_word[ROUTE_TRIP_LSB +: NUM_CIRC] = first_sense_input_i;
		inputs_word[ROUTE_BRK_LSB +: NUM_CIRC] = second_sense_input_i;
	end

	// Read data is prepared in setup so every APB output is a flop;
	// pready is already high in the first access cycle, so transfers take no wait state
	always_comb begin
		ctrl_next = ctrl_reg;
		route_next = route_reg;
		prdata_next = prdata_reg;
		pready_next = 1'b0;
		pslverr_next = 1'b0;
		wdelay = pwdata_i[CTRL_DLY_LSB +: 5];
		if (psel_i && !penable_i) begin
			// Setup: decode and answer next cycle
			pready_next = 1'b1;
			pslverr_next = !addr_ok(paddr_i);
			prdata_next = '0;
			if (!pwrite_i) begin
				unique case (paddr_i)
					CTRL_OFS: prdata_next = ctrl_reg;
					ROUTE_OFS: prdata_next = route_reg;
					STATUS_OFS: prdata_next = status_word;
					INPUTS_OFS: prdata_next = inputs_word;
					default: prdata_next = '0;
				endcase
			end
		end else if (psel_i && penable_i && pready_reg && pwrite_i) begin
			// Access: write lands at the completing edge
			if (paddr_i == CTRL_OFS) begin
				ctrl_next = pwdata_i & CTRL_MASK;
				ctrl_next[CTRL_DLY_LSB +: 5] = clamp_delay(wdelay);
			end
			if (paddr_i == ROUTE_OFS) begin
				route_next = pwdata_i & ROUTE_MASK;
			end
		end
	end

	// Register only
	always_ff @(posedge clk_i or posedge reset_i) begin
		if (reset_i) begin
			ctrl_reg <= CTRL_RESET;
			route_reg <= ROUTE_RESET;
			prdata_reg <= '0;
			pready_reg <= 1'b0;
			pslverr_reg <= 1'b0;
		end else begin
			ctrl_reg <= ctrl_next;
			route_reg <= route_next;
			prdata_reg <= prdata_next;
			pready_reg <= pready_next;
			pslverr_reg <= pslverr_next;
		end
	end

	assign prdata_o = prdata_reg;
	assign pready_o = pready_reg;
	assign pslverr_o = pslverr_reg;

	// ****************************************
	// Sampling timebase
	// ****************************************
	logic [31:0] div_reg; // Prescaler count
	logic [31:0] div_next;
	logic tick_reg; // Sample strobe
	logic tick_next;

	// Free-running prescaler, independent of the switch
	always_comb begin
		tick_next = 1'b0;
		div_next = div_reg + 32'h0000_0001;
		if (div_reg == 32'(SAMPLE_CYCLES - 1)) begin
			div_next = '0;
			tick_next = 1'b1;
		end
	end

	// Register only
	always_ff @(posedge clk_i or posedge reset_i) begin
		if (reset_i) begin
			div_reg <= '0;
			tick_reg <= 1'b0;
		end else begin
			div_reg <= div_next;
			tick_reg <= tick_next;
		end
	end

	// ****************************************
	// Routing check and circuits
	// ****************************************
	logic sup_en; // Supervision switch
	logic mode_two; // Two inputs per circuit
	logic [1:0] circ_cnt; // Supervised circuits
	logic [5:0] limit_samples; // One-input delay in ticks
	logic [NUM_CIRC-1:0] in_use; // Circuit configured
	logic [NUM_CIRC-1:0] mism_now; // Routing mismatch, combinational

	assign sup_en = ctrl_reg[CTRL_EN_BIT];
	assign mode_two = ctrl_reg[CTRL_TWO_BIT];
	assign circ_cnt = ctrl_reg[CTRL_CNT_LSB +: 2];
	assign limit_samples = 6'(ctrl_reg[CTRL_DLY_LSB +: 5] * SAMPLES_PER_SEC);

	generate
		for (genvar i = 0; i < NUM_CIRC; i++) begin : g_circ
			tcs_chan_if ch ();
			assign in_use[i] = 2'(i) < circ_cnt;
			// Missing trip input, or missing breaker input in two-input mode
			assign mism_now[i] = sup_en && in_use[i] && (!route_reg[ROUTE_TRIP_LSB + i]
				|| (mode_two && !route_reg[ROUTE_BRK_LSB + i]));
			assign ch.sample_tick = tick_reg;
			assign ch.active = sup_en && in_use[i] && !mism_now[i];
			assign ch.freeze = system_fault_i;
			assign ch.mode_two = mode_two;
			assign ch.first_in = first_sense_input_i[i];
			assign ch.second_in = second_sense_input_i[i];
			assign ch.limit = limit_samples;
			assign fail_vec[i] = ch.fail;
			tcs_circuit tcs_circuit_i (
				.clk_i(clk_i),
				.reset_i(reset_i),
				.ch(ch)
			);
		end
	endgenerate

	// ****************************************
	// Output flags
	// ****************************************
	logic fail_next; // Common failure
	logic off_next; // Supervision off
	logic many_next; // Any mismatch

	// Failure is masked while a system fault is being handled
	always_comb begin
		fail_next = (|fail_vec) && !system_fault_i;
		off_next = !sup_en || (circ_cnt == 2'h0);
		many_next = |mism_now;
	end

	// Register only
	always_ff @(posedge clk_i or posedge reset_i) begin
		if (reset_i) begin
			fail_reg <= 1'b0;
			off_reg <= 1'b1;
			many_reg <= 1'b0;
			mism_reg <= '0;
		end else begin
			fail_reg <= fail_next;
			off_reg <= off_next;
			many_reg <= many_next;
			mism_reg <= mism_now;
		end
	end

	assign trip_circuit_fail_o = fail_reg;
	assign supervision_off_flag_o = off_reg;
	assign routing_mismatch_alarm_o = many_reg;
	assign circuit_mismatch_o = mism_reg;

	// ****************************************
	// Checks
	// ****************************************
	AST_OFF_FLAG: assert property (@(posedge clk_i) disable iff (reset_i)
		!sup_en |=> supervision_off_flag_o)
		else $error("Off flag missing while switched off");
	AST_MISMATCH: assert property (@(posedge clk_i) disable iff (reset_i)
		sup_en && in_use[0] && !route_reg[ROUTE_TRIP_LSB] |=> circuit_mismatch_o[0]
		&& routing_mismatch_alarm_o)
		else $error("Unrouted circuit not flagged");
	AST_FAULT_MASK: assert property (@(posedge clk_i) disable iff (reset_i)
		system_fault_i |=> !trip_circuit_fail_o)
		else $error("Failure reported during system fault");
	AST_TICK_PERIOD: assert property (@(posedge clk_i) disable iff (reset_i)
		tick_reg |=> !tick_reg)
		else $error("Sample tick longer than one cycle");
	AST_APB_READY: assert property (@(posedge clk_i) disable iff (reset_i)
		psel_i && !penable_i |=> pready_o ##1 !pready_o)
		else $error("APB answer not one cycle after setup");
	// A zero or oversized wait time would make the one-input alarm useless
	AST_DELAY_RANGE: assert property (@(posedge clk_i) disable iff (reset_i)
		ctrl_reg[CTRL_DLY_LSB +: 5] >= DELAY_MIN_S
		&& ctrl_reg[CTRL_DLY_LSB +: 5] <= DELAY_MAX_S)
		else $error("One-input delay outside its range");
	// Any failed circuit reaches the common output outside fault handling
	AST_COMMON_FAIL: assert property (@(posedge clk_i) disable iff (reset_i)
		(|fail_vec) && !system_fault_i |=> trip_circuit_fail_o)
		else $error("Circuit failure missing from common output");
	// No supervised circuits means supervision is off
	AST_COUNT_ZERO_OFF: assert property (@(posedge clk_i) disable iff (reset_i)
		circ_cnt == 2'h0 |=> supervision_off_flag_o)
		else $error("Off flag missing with no circuits");
	// Switched off, routing is not judged at all
	AST_OFF_NO_MISM: assert property (@(posedge clk_i) disable iff (reset_i)
		!sup_en |=> !routing_mismatch_alarm_o)
		else $error("Mismatch flagged while switched off");
	// One-input mode needs only the trip input routed
	AST_ONE_NO_BRK: assert property (@(posedge clk_i) disable iff (reset_i)
		sup_en && !mode_two && in_use[0] && route_reg[ROUTE_TRIP_LSB] |=> !circuit_mismatch_o[0])
		else $error("One-input circuit flagged for breaker routing");
endmodule // tcs_top
`default_nettype wire

// ===== tcs_contacts_model.sv
// Far side of the supervisor: trip relay and breaker auxiliary contacts
// seen through the sense inputs. Assumes contact states change on clk_i.
`timescale 1ns/10ps
`default_nettype none
// ****************************************
// Contact model
// ****************************************
module tcs_contacts_model import tcs_pkg::*; (
	// Contact states
	input wire logic [NUM_CIRC-1:0] trip_closed_i,
	input wire logic [NUM_CIRC-1:0] breaker_on_i,
	input wire logic [NUM_CIRC-1:0] wire_cut_i,
	// Sense inputs
	output logic [NUM_CIRC-1:0] first_o,
	output logic [NUM_CIRC-1:0] second_o
);
	// Closed trip contact shorts the first input; a cut wire kills both
	assign first_o = ~trip_closed_i & ~wire_cut_i;
	// Open breaker closes the NC auxiliary, which powers the second input
	assign second_o = ~breaker_on_i & ~wire_cut_i;
endmodule // tcs_contacts_model
`default_nettype wire

// ===== trip_circuit_supervisor_tb.sv
// Self-checking bench for the trip circuit supervisor top.
// Assumes SAMPLE_CYCLES of 10, so one sample tick every 10 clocks.
`timescale 1ns/10ps
`default_nettype none
module trip_circuit_supervisor_tb import tcs_pkg::*;;
	// ****************************************
	// Signals
	// ****************************************
	logic clk_i, reset_i, psel, penable, pwrite, pready, pslverr, sys_fault;
	logic [7:0] paddr;
	logic [31:0] pwdata, prdata, rdata;
	logic rerr;
	logic [2:0] trip_closed, breaker_on, wire_cut, first, second, mism;
	logic tc_fail, off_flag, mism_any;
	int failures, samples_checked;
	// Contact states feed the sense inputs
	tcs_contacts_model tcs_contacts_model_i (.trip_closed_i(trip_closed),
		.breaker_on_i(breaker_on), .wire_cut_i(wire_cut), .first_o(first), .second_o(second));
	// Short tick keeps every delay a few dozen clocks
	tcs_top #(.SAMPLE_CYCLES(10)) tcs_top_i (.clk_i(clk_i), .reset_i(reset_i),
		.psel_i(psel), .penable_i(penable), .pwrite_i(pwrite), .paddr_i(paddr),
		.pwdata_i(pwdata), .prdata_o(prdata), .pready_o(pready), .pslverr_o(pslverr),
		.first_sense_input_i(first), .second_sense_input_i(second),
		.system_fault_i(sys_fault), .trip_circuit_fail_o(tc_fail),
		.supervision_off_flag_o(off_flag), .routing_mismatch_alarm_o(mism_any),
		.circuit_mismatch_o(mism));
	// ****************************************
	// Helpers
	// ****************************************
	// 50 MHz clock
	initial begin
		clk_i = 1'b0;
		forever #10 clk_i = ~clk_i;
	end
	task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			failures++;
			$display("ERROR %s expected %h seen %h", name, exp, seen);
		end
	endtask
	// APB cycle; request held until pready is sampled high at a rising edge, bounded
	task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
		int n;
		n = 0;
		@(posedge clk_i);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge clk_i);
		penable <= 1'b1;
		// Completing edge: answer, read data and error are taken here
		do begin
			@(posedge clk_i);
			n++;
		end while (pready !== 1'b1 && n < 50);
		rdata = prdata;
		rerr = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		if (pready !== 1'b1) begin
			failures++;
			final_report();
		end
	endtask
	task automatic set_c(input logic [2:0] tc, input logic [2:0] bo, input logic [2:0] wc);
		@(posedge clk_i);
		trip_closed <= tc;
		breaker_on <= bo;
		wire_cut <= wc;
	endtask
	task automatic hold(input int n);
		repeat (n) @(negedge clk_i);
	endtask
	// Alarm must not show at any clock of the span
	task automatic stay_low(input int n, input string name);
		logic seen;
		seen = 1'b0;
		repeat (n) begin
			@(negedge clk_i);
			seen = seen | tc_fail;
		end
		check(name, 32'(seen), 32'h0);
	endtask
	// ****************************************
	// Scenarios
	// ****************************************
	task automatic test_regs();
		check("off after reset", 32'(off_flag), 32'h1);
		bus(1'b0, CTRL_OFS, 32'h0);
		check("ctrl reset", rdata, 32'h0000_020E);
		bus(1'b0, ROUTE_OFS, 32'h0);
		check("route reset", rdata, 32'h0);
		bus(1'b0, INPUTS_OFS, 32'h0);
		check("raw inputs", rdata, 32'h0000_0007);
		bus(1'b0, 8'h10, 32'h0);
		check("unmapped err", 32'(rerr), 32'h1);
		check("unmapped data", rdata, 32'h0);
		// Delay field clamps at both ends
		bus(1'b1, CTRL_OFS, 32'h0000_0005);
		bus(1'b0, CTRL_OFS, 32'h0);
		check("delay floor", rdata, 32'h0000_0105);
		bus(1'b1, CTRL_OFS, 32'h0000_1F05);
		bus(1'b0, CTRL_OFS, 32'h0);
		check("delay ceiling", rdata, 32'h0000_1E05);
		$display("test regs done");
	endtask
	task automatic test_mismatch();
		bus(1'b1, ROUTE_OFS, 32'h0000_0007);
		bus(1'b1, CTRL_OFS, 32'h0000_020F);
		hold(3);
		check("mism all", {29'h0, mism}, 32'h7);
		check("mism any", 32'(mism_any), 32'h1);
		bus(1'b1, ROUTE_OFS, 32'h0000_0037);
		hold(3);
		check("mism third", {29'h0, mism}, 32'h4);
		bus(1'b1, CTRL_OFS, 32'h0000_020D);
		hold(3);
		check("mism one input", {29'h0, mism}, 32'h0);
		bus(1'b1, CTRL_OFS, 32'h0000_0207);
		hold(3);
		check("mism count one", {29'h0, mism}, 32'h0);
		check("mism any off", 32'(mism_any), 32'h0);
		bus(1'b1, ROUTE_OFS, 32'h0000_0077);
		$display("test mismatch done");
	endtask
	task automatic test_two();
		bus(1'b1, CTRL_OFS, 32'h0000_020F);
		// Open breaker, then tripped: both normal
		set_c(3'h0, 3'h0, 3'h0);
		stay_low(40, "open quiet");
		set_c(3'h7, 3'h0, 3'h0);
		stay_low(40, "tripped quiet");
		// Never three abnormal samples in a row
		repeat (3) begin
			set_c(3'h7, 3'h7, 3'h0);
			stay_low(15, "broken run quiet");
			set_c(3'h0, 3'h7, 3'h0);
			stay_low(10, "normal gap quiet");
		end
		set_c(3'h1, 3'h7, 3'h0);
		stay_low(20, "two input early");
		hold(15);
		check("two input alarm", 32'(tc_fail), 32'h1);
		bus(1'b0, STATUS_OFS, 32'h0);
		check("status fail", rdata, 32'h0000_0201);
		set_c(3'h0, 3'h7, 3'h0);
		hold(20);
		check("two input held", 32'(tc_fail), 32'h1);
		hold(15);
		check("two input cleared", 32'(tc_fail), 32'h0);
		// System fault suspends supervision
		@(posedge clk_i);
		sys_fault <= 1'b1;
		set_c(3'h1, 3'h7, 3'h0);
		stay_low(50, "fault quiet");
		set_c(3'h0, 3'h7, 3'h0);
		sys_fault <= 1'b0;
		hold(40);
		$display("test two input done");
	endtask
	task automatic test_one();
		// One input, circuit one, 2 s delay is four ticks
		bus(1'b1, CTRL_OFS, 32'h0000_0205);
		set_c(3'h1, 3'h7, 3'h0);
		stay_low(25, "brief trip quiet");
		set_c(3'h0, 3'h7, 3'h0);
		stay_low(30, "closed quiet");
		set_c(3'h0, 3'h7, 3'h1);
		stay_low(29, "one input early");
		hold(26);
		check("one input alarm", 32'(tc_fail), 32'h1);
		set_c(3'h0, 3'h7, 3'h0);
		hold(29);
		check("one input held", 32'(tc_fail), 32'h1);
		hold(26);
		check("one input cleared", 32'(tc_fail), 32'h0);
		$display("test one input done");
	endtask
	task automatic test_off();
		set_c(3'h0, 3'h7, 3'h7);
		bus(1'b1, CTRL_OFS, 32'h0000_020E);
		stay_low(40, "switch off quiet");
		check("off flag", 32'(off_flag), 32'h1);
		bus(1'b1, CTRL_OFS, 32'h0000_0203);
		stay_low(40, "count zero quiet");
		check("off flag count", 32'(off_flag), 32'h1);
		set_c(3'h0, 3'h7, 3'h0);
		$display("test off done");
	endtask
	// ****************************************
	// Sequence and verdict
	// ****************************************
	task automatic final_report();
		$display("checks %0d mismatches %0d", samples_checked, failures);
		if (failures == 0 && samples_checked > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask
	initial begin
		{psel, penable, pwrite, sys_fault} = 4'h0;
		paddr = 8'h00;
		pwdata = 32'h0;
		{trip_closed, wire_cut} = 6'h00;
		breaker_on = 3'h7;
		failures = 0;
		samples_checked = 0;
		reset_i = 1'b1;
		repeat (5) @(posedge clk_i);
		reset_i <= 1'b0;
		test_regs();
		test_mismatch();
		test_two();
		test_one();
		test_off();
		final_report();
	end
	// Watchdog well beyond the expected several hundred clocks
	initial begin
		repeat (20000) @(posedge clk_i);
		failures++;
		final_report();
	end
endmodule // trip_circuit_supervisor_tb
`default_nettype wire
